// *** hw/adct_pkg.sv ***
// Shared constants and types for the converter timing generator
package adct_pkg;
    // Field positions inside the converter control word
    localparam int unsigned DIV_SEL_LSB   = 14;
    localparam int unsigned WIN_SEL_LSB   = 12;
    // Divider select codes and their ratios
    localparam logic [1:0]  DIV_SEL_BY4   = 2'h0;
    localparam logic [1:0]  DIV_SEL_BY2   = 2'h1;
    localparam logic [1:0]  DIV_SEL_BY16  = 2'h2;
    localparam logic [1:0]  DIV_SEL_BY8   = 2'h3;
    localparam logic [4:0]  RATIO_BY4     = 5'h04;
    localparam logic [4:0]  RATIO_BY2     = 5'h02;
    localparam logic [4:0]  RATIO_BY16    = 5'h10;
    localparam logic [4:0]  RATIO_BY8     = 5'h08;
    // Sample window lengths in basic clock periods
    localparam logic [6:0]  WIN_8         = 7'h08;
    localparam logic [6:0]  WIN_16        = 7'h10;
    localparam logic [6:0]  WIN_32        = 7'h20;
    localparam logic [6:0]  WIN_64        = 7'h40;
    // Conversion phase after the window
    localparam logic [6:0]  CONV_BC       = 7'h28;
    localparam logic [1:0]  TAIL_CPU      = 2'h2;
    // Reset values
    localparam logic [1:0]  DIV_SEL_RST   = 2'h0;
    localparam logic [1:0]  WIN_SEL_RST   = 2'h0;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_TAIL} adct_state_t;
endpackage

// *** hw/adct_bc_if.sv ***
// Interface between the sequencer and the basic clock divider
`timescale 1ns/100ps
`default_nettype none
interface adct_bc_if;
    logic [1:0] div_sel;
    logic       run;
    logic       tick;
    modport seq (output div_sel, output run, input tick);
    modport div (input div_sel, input run, output tick);
endinterface
`default_nettype wire

// *** hw/adct_bc_div.sv ***
// Basic clock divider: one-cycle tick every 2, 4, 8 or 16 core cycles
`timescale 1ns/100ps
`default_nettype none
module adct_bc_div
(
    input  wire logic core_clk,
    input  wire logic rst,
    adct_bc_if.div    bc
);
    import adct_pkg::*;

    logic [4:0] cnt;
    logic [4:0] ratio;
    logic       wrap;

    // Ratio decode from the latched select
    assign ratio = (bc.div_sel == DIV_SEL_BY4)  ? RATIO_BY4  :
                   (bc.div_sel == DIV_SEL_BY2)  ? RATIO_BY2  :
                   (bc.div_sel == DIV_SEL_BY16) ? RATIO_BY16 : RATIO_BY8;
    assign wrap  = (cnt == ratio - 5'h01);

    // Counter restarts with each conversion so phase is repeatable
    always_ff @(posedge core_clk)
    begin
        if (rst || !bc.run)
            cnt <= 5'h00;
        else
            cnt <= wrap ? 5'h00 : cnt + 5'h01;
    end

    // Tick marks the end of each basic clock period
    always_ff @(posedge core_clk)
    begin
        if (rst)
            bc.tick <= 1'b0;
        else
            bc.tick <= bc.run && (cnt == ratio - 5'h02);
    end
endmodule
`default_nettype wire

// *** hw/adct_timing.sv ***
// Converter timing generator: basic clock, sample window, conversion phase
// How it works
// - Basic clock is core clock divided by 4, 2, 16 or 8 per select.
// - Sample window lasts 8, 16, 32 or 64 basic clock periods.
// - Conversion lasts window plus 40 basic periods plus 2 core cycles.
// - Input tracking stops when the sample window ends.
`timescale 1ns/100ps
`default_nettype none
module adct_timing
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [15:0] converter_control_word,
    input  wire logic        start,
    output logic             busy,
    output logic             sample_track,
    output logic             convert_step,
    output logic             done
);
    import adct_pkg::*;

    adct_bc_if   bc ();
    adct_state_t state;
    adct_state_t next_state;
    logic [1:0]  win_sel;
    logic [1:0]  div_sel;
    logic [6:0]  periods;
    logic [6:0]  win_len;
    logic [1:0]  tail;
    logic        take;
    logic        win_end;
    logic        conv_end;

    adct_bc_div u_div (
        .core_clk (core_clk),
        .rst      (rst),
        .bc       (bc)
    );

    // Window length decode from the captured select
    assign win_len  = (win_sel == 2'h0) ? WIN_8  :
                      (win_sel == 2'h1) ? WIN_16 :
                      (win_sel == 2'h2) ? WIN_32 : WIN_64;
    assign take     = (state == ST_IDLE) && start;
    assign win_end  = (state == ST_SAMPLE) && bc.tick && (periods == win_len - 7'h01);
    assign conv_end = (state == ST_CONVERT) && bc.tick && (periods == CONV_BC - 7'h01);
    assign bc.div_sel = div_sel;
    assign bc.run     = (state == ST_SAMPLE) || (state == ST_CONVERT);

    // Capture selects only at start; later writes wait for the next run
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            div_sel <= DIV_SEL_RST;
            win_sel <= WIN_SEL_RST;
        end
        else if (take)
        begin
            div_sel <= converter_control_word[DIV_SEL_LSB +: 2];
            win_sel <= converter_control_word[WIN_SEL_LSB +: 2];
        end
    end

    // Next state
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:    if (start) next_state = ST_SAMPLE;
            ST_SAMPLE:  if (win_end) next_state = ST_CONVERT;
            ST_CONVERT: if (conv_end) next_state = ST_TAIL;
            ST_TAIL:    if (tail == TAIL_CPU - 2'h1) next_state = ST_IDLE;
            default:    next_state = ST_IDLE;
        endcase
    end

    // State, period and tail counters
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || take || win_end || conv_end)
            periods <= 7'h00;
        else if (bc.tick)
            periods <= periods + 7'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || state != ST_TAIL)
            tail <= 2'h0;
        else
            tail <= tail + 2'h1;
    end

    // Registered outputs; track drops the cycle the window closes
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            busy         <= 1'b0;
            sample_track <= 1'b0;
            convert_step <= 1'b0;
            done         <= 1'b0;
        end
        else
        begin
            busy         <= (next_state != ST_IDLE);
            sample_track <= (next_state == ST_SAMPLE);
            convert_step <= (state == ST_CONVERT) && bc.tick;
            done         <= (state == ST_TAIL) && (next_state == ST_IDLE);
        end
    end

    // Helper: cycles since start, for timing checks
    logic [11:0] run_cnt;
    logic [4:0]  ratio_a;
    logic [6:0]  win_a;
    always_ff @(posedge core_clk)
    begin
        if (rst || take)
            run_cnt <= 12'h000;
        else if (busy)
            run_cnt <= run_cnt + 12'h001;
    end
    assign ratio_a = (div_sel == DIV_SEL_BY4)  ? RATIO_BY4  :
                     (div_sel == DIV_SEL_BY2)  ? RATIO_BY2  :
                     (div_sel == DIV_SEL_BY16) ? RATIO_BY16 : RATIO_BY8;
    assign win_a   = win_len;

    // Helper: steps seen in this run and cycles since the last one
    logic [6:0]  step_cnt;
    logic [4:0]  gap;
    always_ff @(posedge core_clk)
    begin
        if (rst || take)
            step_cnt <= 7'h00;
        else if (convert_step)
            step_cnt <= step_cnt + 7'h01;
    end

    // Gap saturates so a long idle spell cannot wrap into a false match
    always_ff @(posedge core_clk)
    begin
        if (rst || convert_step)
            gap <= 5'h00;
        else if (gap != 5'h1F)
            gap <= gap + 5'h01;
    end

    sequence s_started;
        !busy ##1 busy;
    endsequence

    // Window close and the two-cycle tail
    sequence s_window_close;
        $fell(sample_track);
    endsequence

    sequence s_tail_pass;
        (state == ST_TAIL) ##1 (state == ST_TAIL) ##1 (state == ST_IDLE);
    endsequence

    a_done_time: assert property (@(posedge core_clk) disable iff (rst)
        done |-> (32'(run_cnt) + 32'd1 ==
                  (32'(win_a) + 32'(CONV_BC)) * 32'(ratio_a) + 32'(TAIL_CPU) + 32'd1))
        else $error("conversion length wrong");
    a_track_len: assert property (@(posedge core_clk) disable iff (rst)
        $fell(sample_track) |-> (32'(run_cnt) == 32'(win_a) * 32'(ratio_a)))
        else $error("sample window length wrong");
    a_tick_space: assert property (@(posedge core_clk) disable iff (rst)
        (bc.tick && div_sel == DIV_SEL_BY2 && bc.run) |=> !bc.tick ##1 (bc.tick || !bc.run))
        else $error("divide by two spacing wrong");
    a_track_off: assert property (@(posedge core_clk) disable iff (rst)
        (state == ST_CONVERT || state == ST_TAIL) |-> !sample_track)
        else $error("tracking after window");
    a_sel_hold: assert property (@(posedge core_clk) disable iff (rst)
        (busy && !take && $past(busy)) |-> $stable(div_sel) && $stable(win_sel))
        else $error("select changed mid conversion");
    a_start_track: assert property (@(posedge core_clk) disable iff (rst)
        s_started |-> sample_track)
        else $error("no tracking at start");

    // Step count, spacing and the first step after the window
    a_step_count: assert property (@(posedge core_clk) disable iff (rst)
        done |-> (step_cnt == CONV_BC))
        else $error("conversion step count wrong");
    a_step_space: assert property (@(posedge core_clk) disable iff (rst)
        (convert_step && step_cnt != 7'h00) |-> (gap + 5'h01 == ratio_a))
        else $error("conversion step spacing wrong");
    a_first_step: assert property (@(posedge core_clk) disable iff (rst)
        s_window_close |-> ##[1:16] convert_step)
        else $error("no step after window");
    a_win_close: assert property (@(posedge core_clk) disable iff (rst)
        s_window_close |-> (state == ST_CONVERT) && (periods == 7'h00))
        else $error("window closed off a period edge");

    // Phase order, tail length and quiet idle
    a_tail_pass: assert property (@(posedge core_clk) disable iff (rst)
        conv_end |=> s_tail_pass)
        else $error("tail length wrong");
    a_busy_done: assert property (@(posedge core_clk) disable iff (rst)
        done |-> !busy && $past(busy))
        else $error("done without a finished run");
    a_step_busy: assert property (@(posedge core_clk) disable iff (rst)
        convert_step |-> busy)
        else $error("step outside a conversion");
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
        !busy |-> !sample_track && !convert_step)
        else $error("activity while idle");
    a_track_step: assert property (@(posedge core_clk) disable iff (rst)
        sample_track |-> !convert_step)
        else $error("step during sample window");
endmodule
`default_nettype wire

// *** dv/tb_adc_conversion_timing.sv ***
// Self-checking bench for the converter timing generator
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_timing;
    import adct_pkg::*;
    logic        core_clk;
    logic        rst;
    logic [15:0] converter_control_word;
    logic        start;
    logic        busy;
    logic        sample_track;
    logic        convert_step;
    logic        done;
    int          bad_count;
    int          checks_done;

    adct_timing dut_u (
        .core_clk               (core_clk),
        .rst                    (rst),
        .converter_control_word (converter_control_word),
        .start                  (start),
        .busy                   (busy),
        .sample_track           (sample_track),
        .convert_step           (convert_step),
        .done                   (done)
    );

    // Free-running 50 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check_int(input string what, input int exp, input int got);
        checks_done++;
        if (exp != got)
        begin
            bad_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (exp !== got)
        begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One conversion; selects are scrambled and start retried mid-run
    task automatic run_conv(input logic [1:0] d, input logic [1:0] w);
        int r;
        int wl;
        int n;
        int st;
        int cs;
        int dn;
        r  = (d == 2'h0) ? 4 : (d == 2'h1) ? 2 : (d == 2'h2) ? 16 : 8;
        wl = 8 << w;
        converter_control_word = {d, w, 12'h000};
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        n = 0;
        st = 0;
        cs = 0;
        dn = 0;
        // Cycle zero already shows the window opening
        check_bit("busy at start", 1'b1, busy);
        check_bit("track at start", 1'b1, sample_track);
        if (sample_track === 1'b1)
            st++;
        while (dn == 0 && n < 3000)
        begin
            @(posedge core_clk);
            #1 n++;
            // Rewrite and retrigger while busy: both must be ignored
            if (n == 3)
            begin
                converter_control_word = ~converter_control_word;
                start = 1'b1;
            end
            if (n == 4)
                start = 1'b0;
            if (sample_track === 1'b1)
                st++;
            if (convert_step === 1'b1)
                cs++;
            if (done === 1'b1)
                dn = n;
        end
        check_int("conversion cycles", (wl + 40) * r + 2, dn);
        check_int("sample window cycles", wl * r, st);
        check_int("convert steps", 40, cs);
        check_bit("busy at done", 1'b0, busy);
    endtask

    // Reset in mid-conversion must clear every output at once
    task automatic reset_mid;
        converter_control_word = {DIV_SEL_BY2, 2'h0, 12'h000};
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        repeat (30) @(posedge core_clk);
        #1 rst = 1'b1;
        @(posedge core_clk);
        #1 check_bit("busy in reset", 1'b0, busy);
        check_bit("track in reset", 1'b0, sample_track);
        check_bit("step in reset", 1'b0, convert_step);
        check_bit("done in reset", 1'b0, done);
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        @(posedge core_clk);
        #1 check_bit("busy after mid reset", 1'b0, busy);
        check_bit("track after mid reset", 1'b0, sample_track);
    endtask

    // Watchdog: all runs together need well under 600 us
    initial
    begin
        #600000;
        bad_count++;
        conclude();
    end

    // Main sequence: reset, then every divider and window code
    initial
    begin
        bad_count = 0;
        checks_done = 0;
        rst = 1'b1;
        start = 1'b0;
        converter_control_word = 16'h0000;
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        check_bit("busy after reset", 1'b0, busy);
        check_bit("done after reset", 1'b0, done);
        // Stimulus plays software; basic clock limits are its burden, not checked
        for (int d = 0; d < 4; d++)
            for (int w = 0; w < 4; w++)
                run_conv(d[1:0], w[1:0]);
        reset_mid();
        run_conv(2'h1, 2'h0);
        conclude();
    end
endmodule
`default_nettype wire
